// file: design/aarc_cmp.v
// Equality compare of a received address against a configured one
module aarc_cmp
#(
  parameter W = 16
)
(
  input  wire [W-1:0] rx_addr,
  input  wire [W-1:0] own_addr,
  output wire         hit
);

  // Plain compare; shared by short, network id and extended address
  assign hit = (rx_addr == own_addr);

endmodule

// file: design/aarc_consts.vh
// Offsets, field positions, reset values and timing values in ns of the auto-ack block
`ifndef AARC_CONSTS_VH
`define AARC_CONSTS_VH

// ----------------------------------------
// Register indexes (byte address = 4 * index)
// ----------------------------------------
`define AARC_IDX_RX_PROTECT   8'h0C
`define AARC_IDX_SHORT_LO     8'h20
`define AARC_IDX_SHORT_HI     8'h21
`define AARC_IDX_NETID_LO     8'h22
`define AARC_IDX_NETID_HI     8'h23
`define AARC_IDX_EXT_FIRST    8'h24
`define AARC_IDX_EXT_LAST     8'h2B
`define AARC_IDX_ACK_SLOT     8'h2C
`define AARC_IDX_ACK_BEHAV    8'h2E
`define AARC_IDX_STATUS       8'h30

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AARC_BIT_RX_PROTECT   7
`define AARC_BIT_SLOTTED      0
`define AARC_BIT_COORD        3
`define AARC_BIT_PEND         5
`define AARC_FVN_HI           7
`define AARC_FVN_LO           6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AARC_RST_RX_PROTECT   8'h00
`define AARC_RST_SHORT        8'hFF
`define AARC_RST_NETID        8'hFF
`define AARC_RST_EXT          8'h00
`define AARC_RST_ACK_SLOT     8'h00
`define AARC_RST_ACK_BEHAV    8'h40

// ----------------------------------------
// Address and frame constants
// ----------------------------------------
`define AARC_BCAST_16         16'hFFFF
`define AARC_MODE_NONE        2'h0
`define AARC_MODE_SHORT       2'h2
`define AARC_MODE_EXT         2'h3
`define AARC_FT_DATA          3'h1
`define AARC_FT_CMD           3'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define AARC_CLK_PERIOD_NS    4
`define AARC_ACK_TIME_NS      192000

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define AARC_RESP_OKAY        2'h0
`define AARC_RESP_SLVERR      2'h2

`endif

// file: design/aarc_sync.v
// Two-flop synchroniser for a level arriving from a pin
module aarc_sync
(
  input  wire aclk,
  input  wire aresetn,
  input  wire din,
  output wire dout
);

  reg meta_r;  // First stage, read only by the second
  reg sync_r;  // Second stage, safe to use

  // ----------------------------------------
  // Synchroniser stages
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;

endmodule

// file: design/aarc_top.v
// Auto-acknowledge configuration, address filter and ack timing with AXI4-Lite registers
`include "aarc_consts.vh"

module aarc_top
#(
  parameter ACK_TURN_CYC = `AARC_ACK_TIME_NS / `AARC_CLK_PERIOD_NS
)
(
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite slave
  input  wire [9:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [9:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Parsed header from the receiver
  input  wire        receive_auto_ack,
  input  wire        hdr_valid,
  input  wire [2:0]  hdr_frame_type,
  input  wire        hdr_ack_request,
  input  wire [1:0]  hdr_frame_version,
  input  wire [1:0]  hdr_dst_mode,
  input  wire [15:0] hdr_dst_netid,
  input  wire [63:0] hdr_dst_addr,
  input  wire        hdr_data_request,
  input  wire        hdr_fcs_ok,
  // Slot trigger pin
  input  wire        sleep_transmit_trigger,
  // Results
  output reg         addr_match,
  output reg         buffer_protect,
  output reg         ack_start,
  output reg         ack_frame_pending
);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  reg [7:0]  rx_protect_ctrl_r;     // Receive protection
  reg [15:0] short_address_r;       // Own short address
  reg [15:0] network_id_r;          // Own network id
  reg [63:0] extended_address_r;    // Own 64-bit address
  reg [7:0]  ack_slot_ctrl_r;       // Slotted ack control
  reg [7:0]  ack_behaviour_ctrl_r;  // Role, pending, version mode

  // ----------------------------------------
  // Ack sequencing state
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;  // No ack under way
  localparam ST_TURN = 2'h1;  // Waiting the turnaround time
  localparam ST_SLOT = 2'h2;  // Waiting for the slot trigger

  reg [1:0]  state_r;           // Ack state
  reg [1:0]  state_nxt;         // Next ack state
  reg [15:0] turn_cnt_r;        // Turnaround counter
  reg        trig_d_r;          // Delayed trigger for edge detect
  reg        last_reject_r;     // Last ack suppressed by version
  wire       trig_s;            // Synchronised trigger
  wire       trig_rise;         // Trigger rising edge

  // ----------------------------------------
  // Address compare results
  // ----------------------------------------
  wire hit_short;    // Short address equal
  wire hit_bshort;   // Broadcast short address
  wire hit_netid;    // Network id equal
  wire hit_bnet;     // Broadcast network id
  wire hit_ext;      // Extended address equal

  // ----------------------------------------
  // Trigger pin synchroniser
  // ----------------------------------------
  aarc_sync u_trig_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (sleep_transmit_trigger),
    .dout    (trig_s)
  );

  assign trig_rise = trig_s & ~trig_d_r;

  // ----------------------------------------
  // Address comparators
  // ----------------------------------------
  aarc_cmp #(.W(16)) u_cmp_short
  (
    .rx_addr  (hdr_dst_addr[15:0]),
    .own_addr (short_address_r),
    .hit      (hit_short)
  );

  aarc_cmp #(.W(16)) u_cmp_bshort
  (
    .rx_addr  (hdr_dst_addr[15:0]),
    .own_addr (`AARC_BCAST_16),
    .hit      (hit_bshort)
  );

  aarc_cmp #(.W(16)) u_cmp_net
  (
    .rx_addr  (hdr_dst_netid),
    .own_addr (network_id_r),
    .hit      (hit_netid)
  );

  aarc_cmp #(.W(16)) u_cmp_bnet
  (
    .rx_addr  (hdr_dst_netid),
    .own_addr (`AARC_BCAST_16),
    .hit      (hit_bnet)
  );

  aarc_cmp #(.W(64)) u_cmp_ext
  (
    .rx_addr  (hdr_dst_addr),
    .own_addr (extended_address_r),
    .hit      (hit_ext)
  );

  // ----------------------------------------
  // Frame filter and ack decision
  // ----------------------------------------
  reg short_set;     // A short address is configured
  reg net_ok;        // Network id acceptable
  reg accept;        // Destination accepted
  reg ver_ok;        // Version admitted
  reg want_ack;      // Ack to be sent

  // Combinational filter over the parsed header
  always @*
  begin
    short_set = (short_address_r != `AARC_BCAST_16);
    net_ok    = hit_netid | hit_bnet;
    accept    = 1'b0;
    case (hdr_dst_mode)
      `AARC_MODE_NONE:  accept = ack_behaviour_ctrl_r[`AARC_BIT_COORD];
      `AARC_MODE_SHORT: accept = net_ok & (hit_bshort | (short_set & hit_short));
      `AARC_MODE_EXT:   accept = net_ok & hit_ext;
      default:          accept = 1'b0;
    endcase
    case (ack_behaviour_ctrl_r[`AARC_FVN_HI:`AARC_FVN_LO])
      2'h0:    ver_ok = (hdr_frame_version == 2'h0);
      2'h1:    ver_ok = (hdr_frame_version <= 2'h1);
      2'h2:    ver_ok = (hdr_frame_version <= 2'h2);
      default: ver_ok = 1'b1;
    endcase
    want_ack = accept & hdr_ack_request & hdr_fcs_ok & ver_ok &
               ((hdr_frame_type == `AARC_FT_DATA) | (hdr_frame_type == `AARC_FT_CMD));
  end

  // ----------------------------------------
  // Ack state machine, next state
  // ----------------------------------------
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (hdr_valid & receive_auto_ack & want_ack)
        begin
          if (ack_slot_ctrl_r[`AARC_BIT_SLOTTED])
            state_nxt = ST_SLOT;
          else
            state_nxt = ST_TURN;
        end
      end
      ST_TURN:
      begin
        // Standard turnaround elapsed
        if (turn_cnt_r == 16'h0001)
          state_nxt = ST_IDLE;
      end
      ST_SLOT:
      begin
        if (trig_rise)
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Ack state machine, registers and outputs
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r           <= ST_IDLE;
      turn_cnt_r        <= 16'h0000;
      trig_d_r          <= 1'b0;
      ack_start         <= 1'b0;
      ack_frame_pending <= 1'b0;
      addr_match        <= 1'b0;
      buffer_protect    <= 1'b0;
      last_reject_r     <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      trig_d_r   <= trig_s;
      ack_start  <= 1'b0;
      addr_match <= hdr_valid & receive_auto_ack & accept;
      if ((state_r == ST_IDLE) && (state_nxt == ST_TURN))
        turn_cnt_r <= ACK_TURN_CYC[15:0];
      else if (turn_cnt_r != 16'h0000)
        turn_cnt_r <= turn_cnt_r - 16'h0001;
      // Ack launches when the wait ends
      if ((state_r != ST_IDLE) && (state_nxt == ST_IDLE))
        ack_start <= 1'b1;
      if (hdr_valid & receive_auto_ack)
      begin
        ack_frame_pending <= ack_behaviour_ctrl_r[`AARC_BIT_PEND] & hdr_data_request;
        // Version rejection is kept for software to inspect
        last_reject_r     <= accept & hdr_ack_request & ~ver_ok;
        if (rx_protect_ctrl_r[`AARC_BIT_RX_PROTECT] & accept & hdr_fcs_ok)
          buffer_protect <= 1'b1;
      end
      if (!rx_protect_ctrl_r[`AARC_BIT_RX_PROTECT])
        buffer_protect <= 1'b0;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  wire       wr_go;      // Address and data both offered
  wire [7:0] wr_idx;     // Word index of the write
  wire       wr_ok;      // Index is mapped
  reg  [2:0] ext_sel;    // Extended address byte select

  // Both taken together; no response slot means no accept
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign wr_idx        = s_axi_awaddr[9:2];
  assign wr_ok         = (wr_idx == `AARC_IDX_RX_PROTECT) |
                         ((wr_idx >= `AARC_IDX_SHORT_LO) & (wr_idx <= `AARC_IDX_EXT_LAST)) |
                         (wr_idx == `AARC_IDX_ACK_SLOT) | (wr_idx == `AARC_IDX_ACK_BEHAV);

  // Register writes; byte lane 0 carries the 8-bit value
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_protect_ctrl_r    <= `AARC_RST_RX_PROTECT;
      short_address_r      <= {`AARC_RST_SHORT, `AARC_RST_SHORT};
      network_id_r         <= {`AARC_RST_NETID, `AARC_RST_NETID};
      extended_address_r   <= {8{`AARC_RST_EXT}};
      ack_slot_ctrl_r      <= `AARC_RST_ACK_SLOT;
      ack_behaviour_ctrl_r <= `AARC_RST_ACK_BEHAV;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= `AARC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `AARC_RESP_OKAY : `AARC_RESP_SLVERR;
        if (s_axi_wstrb[0])
        begin
          case (wr_idx)
            `AARC_IDX_RX_PROTECT: rx_protect_ctrl_r     <= s_axi_wdata[7:0];
            `AARC_IDX_SHORT_LO:   short_address_r[7:0]  <= s_axi_wdata[7:0];
            `AARC_IDX_SHORT_HI:   short_address_r[15:8] <= s_axi_wdata[7:0];
            `AARC_IDX_NETID_LO:   network_id_r[7:0]     <= s_axi_wdata[7:0];
            `AARC_IDX_NETID_HI:   network_id_r[15:8]    <= s_axi_wdata[7:0];
            `AARC_IDX_ACK_SLOT:   ack_slot_ctrl_r       <= s_axi_wdata[7:0];
            `AARC_IDX_ACK_BEHAV:  ack_behaviour_ctrl_r  <= s_axi_wdata[7:0];
            default:
            begin
              // Extended address bytes, byte 0 lowest
              if ((wr_idx >= `AARC_IDX_EXT_FIRST) & (wr_idx <= `AARC_IDX_EXT_LAST))
                extended_address_r[ext_sel*8 +: 8] <= s_axi_wdata[7:0];
            end
          endcase
        end
      end
    end
  end

  // Byte select within the extended address
  always @*
  begin
    ext_sel = wr_idx[2:0] - 3'h4;
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  wire [7:0] rd_idx;     // Word index of the read
  wire [2:0] rd_sel;     // Extended byte select for reads
  reg  [7:0] rd_byte;    // Selected register value
  reg        rd_ok;      // Index is mapped

  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_idx        = s_axi_araddr[9:2];
  assign rd_sel        = rd_idx[2:0] - 3'h4;

  // Read mux; status shows live ack state
  always @*
  begin
    rd_ok   = 1'b1;
    rd_byte = 8'h00;
    case (rd_idx)
      `AARC_IDX_RX_PROTECT: rd_byte = rx_protect_ctrl_r;
      `AARC_IDX_SHORT_LO:   rd_byte = short_address_r[7:0];
      `AARC_IDX_SHORT_HI:   rd_byte = short_address_r[15:8];
      `AARC_IDX_NETID_LO:   rd_byte = network_id_r[7:0];
      `AARC_IDX_NETID_HI:   rd_byte = network_id_r[15:8];
      `AARC_IDX_ACK_SLOT:   rd_byte = ack_slot_ctrl_r;
      `AARC_IDX_ACK_BEHAV:  rd_byte = ack_behaviour_ctrl_r;
      `AARC_IDX_STATUS:     rd_byte = {4'h0, last_reject_r, buffer_protect, state_r};
      default:
      begin
        if ((rd_idx >= `AARC_IDX_EXT_FIRST) & (rd_idx <= `AARC_IDX_EXT_LAST))
          rd_byte = extended_address_r[rd_sel*8 +: 8];
        else
          rd_ok = 1'b0;
      end
    endcase
  end

  // Read data register, held until taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `AARC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid & ~s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_ok ? `AARC_RESP_OKAY : `AARC_RESP_SLVERR;
      end
    end
  end

endmodule

// file: testbench/aarc_node_model.sv
// Remote node model: hands parsed frame headers to the block, one per call
module aarc_node_model
(
  input  wire        aclk,
  output wire        hdr_valid,
  output wire [2:0]  hdr_frame_type,
  output wire        hdr_ack_request,
  output wire [1:0]  hdr_frame_version,
  output wire [1:0]  hdr_dst_mode,
  output wire [15:0] hdr_dst_netid,
  output wire [63:0] hdr_dst_addr,
  output wire        hdr_data_request,
  output wire        hdr_fcs_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        vld_r = 1'b0; // Header strobe
  logic [89:0] fld_r = '0;   // Packed header fields
  assign hdr_valid = vld_r;
  assign {hdr_frame_type, hdr_ack_request, hdr_frame_version, hdr_dst_mode,
          hdr_dst_netid, hdr_dst_addr, hdr_data_request, hdr_fcs_ok} = fld_r;
  // One-cycle strobe after gap idle cycles; released fields are inverted
  // so a late sample never sees stale but plausible values
  task automatic send(input int gap, input [2:0] ft, input ar, input [1:0] ver, md,
                      input [15:0] nid, input [63:0] ad, input dr, fcs);
    repeat (gap + 1) @(posedge aclk);
    vld_r <= 1'b1;
    fld_r <= {ft, ar, ver, md, nid, ad, dr, fcs};
    @(posedge aclk);
    vld_r <= 1'b0;
    fld_r <= ~{ft, ar, ver, md, nid, ad, dr, fcs};
  endtask
endmodule

// file: testbench/aarc_top_sva.sv
// Checker for the auto-ack block: register bus handshakes and header responses
module aarc_top_chk
#(
  parameter ACK_TURN_CYC = 8
)
(
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic        receive_auto_ack,
  input logic        hdr_valid,
  input logic        hdr_data_request,
  input logic        addr_match,
  input logic        ack_start,
  input logic        ack_frame_pending,
  input logic        buffer_protect,
  input logic        hdr_fcs_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write taken: both channels accepted together
  sequence s_wr;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready;
  endsequence
  // Read address taken
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_resp;
    s_wr |=> s_axi_bvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_rd_resp;
    s_rd |=> s_axi_rvalid;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_r_shape;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready;
  endproperty
  property p_match_cause;
    addr_match |-> $past(hdr_valid) && $past(receive_auto_ack);
  endproperty
  property p_pend_zero;
    hdr_valid && receive_auto_ack && !hdr_data_request |=> !ack_frame_pending;
  endproperty
  // Protection only ever starts on a header that arrived with a good checksum
  property p_protect_cause;
    $rose(buffer_protect) |-> $past(hdr_valid) && $past(receive_auto_ack) && $past(hdr_fcs_ok);
  endproperty
  // An ack needs a new header and a new wait, so pulses never crowd
  property p_ack_pulse;
    ack_start |=> !ack_start [*3];
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write not answered");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  a_w_block: assert property (p_w_block)
    else $error("write taken while response pending");
  a_rd_resp: assert property (p_rd_resp)
    else $error("read not answered");
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  a_r_shape: assert property (p_r_shape)
    else $error("read word malformed");
  a_match_cause: assert property (p_match_cause)
    else $error("match without header");
  a_pend_zero: assert property (p_pend_zero)
    else $error("pending set without data request");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack launch not a single pulse");
  a_protect_cause: assert property (p_protect_cause)
    else $error("protection set without a good header");
endmodule

bind aarc_top aarc_top_chk #(.ACK_TURN_CYC(ACK_TURN_CYC)) aarc_top_chk_i
(
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .receive_auto_ack, .hdr_valid,
  .hdr_data_request, .addr_match, .ack_start, .ack_frame_pending, .buffer_protect,
  .hdr_fcs_ok
);

// file: testbench/aarc_top_test.sv
// Self-checking bench for the auto-ack configuration block
`include "aarc_consts.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module aarc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int        TURN = 8;        // Shortened ack turnaround
  localparam int        LIM  = TURN + 6; // Bound on any ack wait
  localparam [63:0]     EXT  = 64'h1716151413121110;
  localparam [1:0]      OK   = `AARC_RESP_OKAY;
  localparam [1:0]      ERR  = `AARC_RESP_SLVERR;
  logic                 aclk, aresetn, receive_auto_ack, sleep_transmit_trigger;
  logic                 s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [9:0]           s_axi_awaddr, s_axi_araddr;
  logic [31:0]          s_axi_wdata;
  logic [3:0]           s_axi_wstrb;
  wire                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]            s_axi_bresp, s_axi_rresp, hdr_frame_version, hdr_dst_mode;
  wire [31:0]           s_axi_rdata;
  wire                  hdr_valid, hdr_ack_request, hdr_data_request, hdr_fcs_ok;
  wire [2:0]            hdr_frame_type;
  wire [15:0]           hdr_dst_netid;
  wire [63:0]           hdr_dst_addr;
  wire                  addr_match, buffer_protect, ack_start, ack_frame_pending;
  int                   failures, checks_done, n, gap;
  logic [7:0]           ri [9] = '{8'h0C, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h2B, 8'h2C, 8'h2E};
  logic [7:0]           rv [9] = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h40};

  aarc_top #(.ACK_TURN_CYC(TURN)) aarc_top_i
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .receive_auto_ack, .hdr_valid, .hdr_frame_type,
    .hdr_ack_request, .hdr_frame_version, .hdr_dst_mode, .hdr_dst_netid, .hdr_dst_addr,
    .hdr_data_request, .hdr_fcs_ok, .sleep_transmit_trigger, .addr_match,
    .buffer_protect, .ack_start, .ack_frame_pending
  );
  aarc_node_model aarc_node_model_i
  (
    .aclk, .hdr_valid, .hdr_frame_type, .hdr_ack_request, .hdr_frame_version,
    .hdr_dst_mode, .hdr_dst_netid, .hdr_dst_addr, .hdr_data_request, .hdr_fcs_ok
  );
  // ----------------------------------------
  // Bus and frame tasks
  // ----------------------------------------
  // Write: address and data offered together, held until taken
  task automatic wr(input [7:0] i, input [7:0] d, input [3:0] s, input [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask
  task automatic rd(input [7:0] i, input [7:0] e, input [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, {24'h0, e})
    `CHK(s_axi_rresp, er)
  endtask
  task automatic cfg(input [7:0] i, input [7:0] d);
    @(posedge aclk);
    receive_auto_ack <= 1'b0;
    wr(i, d, 4'h1, OK);
    receive_auto_ack <= 1'b1;
  endtask
  // Bounded wait for an ack launch; n counts edges
  task automatic wack(input int lim);
    n = 0;
    while (n <= lim && ack_start !== 1'b1)
    begin
      @(posedge aclk);
      #1;
      n++;
    end
  endtask
  task automatic fr(input [2:0] ft, input ar, input [1:0] v, md, input [63:0] ad,
                    input dr, fcs, em, ea, ep);
    aarc_node_model_i.send(gap, ft, ar, v, md, 16'hABCD, ad, dr, fcs);
    #1;
    `CHK(addr_match, em)
    `CHK(ack_frame_pending, ep)
    wack(LIM);
    `CHK(n <= LIM, ea)
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Run needs about 600 cycles
  initial
  begin
    repeat (5000) @(posedge aclk);
    failures++;
    end_sim();
  end
  initial
  begin
    {aresetn, receive_auto_ack, sleep_transmit_trigger, s_axi_awvalid} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    gap = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ri[k]) rd(ri[k], rv[k], OK);
    rd(8'h01, 8'h00, ERR);
    wr(8'h30, 8'h55, 4'h1, ERR);
    wr(8'h2C, 8'h01, 4'h0, OK);
    rd(8'h2C, 8'h00, OK);
    // Network id and extended address; short address left unset
    cfg(8'h22, 8'hCD);
    cfg(8'h23, 8'hAB);
    for (int k = 0; k < 8; k++) cfg(8'h24 + k[7:0], 8'h10 + k[7:0]);
    rd(8'h2B, 8'h17, OK);
    fr(1, 0, 0, 2, 'hFFFF, 0, 1, 1, 0, 0);
    fr(1, 0, 0, 2, 'h1234, 0, 1, 0, 0, 0);
    fr(1, 0, 0, 3, EXT, 0, 1, 1, 0, 0);
    fr(1, 0, 0, 3, EXT ^ 64'h1, 0, 1, 0, 0, 0);
    cfg(8'h20, 8'h34);
    cfg(8'h21, 8'h12);
    fr(1, 1, 0, 2, 'h1234, 0, 1, 1, 1, 0);
    // Launch edge of the header plus the turnaround, less the edge spent sending
    `CHK(n, TURN)
    fr(1, 1, 0, 0, 0, 0, 1, 0, 0, 0);
    cfg(8'h2E, 8'h48);
    fr(1, 1, 0, 0, 0, 0, 1, 1, 1, 0);
    rd(8'h2E, 8'h48, OK);
    for (int c = 0; c < 4; c++)
    begin
      cfg(8'h2E, {c[1:0], 6'h0});
      for (int v = 0; v < 4; v++) fr(1, 1, v[1:0], 2, 'h1234, 0, 1, 1, c == 3 || v <= c, 0);
      // Status shows the version rejection of the last header
      if (c == 0) rd(8'h30, 8'h08, OK);
    end
    cfg(8'h2E, 8'h60);
    fr(3, 1, 0, 2, 'h1234, 1, 1, 1, 1, 1);
    fr(3, 1, 0, 2, 'h1234, 0, 1, 1, 1, 0);
    fr(1, 1, 0, 2, 'h1234, 0, 1, 1, 1, 0);
    cfg(8'h2E, 8'h40);
    fr(3, 1, 0, 2, 'h1234, 1, 1, 1, 1, 0);
    // Slow sender while protection is exercised
    cfg(8'h0C, 8'h80);
    gap = 3;
    fr(1, 1, 0, 2, 'h1234, 0, 0, 1, 0, 0);
    `CHK(buffer_protect, 1'b0)
    fr(1, 1, 0, 2, 'h1234, 0, 1, 1, 1, 0);
    `CHK(buffer_protect, 1'b1)
    cfg(8'h0C, 8'h00);
    repeat (2) @(posedge aclk);
    #1;
    `CHK(buffer_protect, 1'b0)
    gap = 0;
    cfg(8'h2C, 8'h01);
    fr(1, 1, 0, 2, 'h1234, 0, 1, 1, 0, 0);
    // Ack parked in the slot wait until the trigger comes
    rd(8'h30, 8'h02, OK);
    @(posedge aclk);
    sleep_transmit_trigger <= 1'b1;
    wack(LIM);
    `CHK(n <= LIM, 1'b1)
    sleep_transmit_trigger <= 1'b0;
    cfg(8'h2C, 8'h00);
    end_sim();
  end
endmodule
